// [rtl/exrs_map.svh]
/*
  Constants of the exception and reset sequencer.
  Assumes inclusion by bare name from rtl/.
*/
`ifndef EXRS_MAP_SVH
`define EXRS_MAP_SVH

`define EXRS_VEC_RESET      6'h00
`define EXRS_VEC_MAX        6'h3c
`define EXRS_TRAP_VEC_BASE  6'h08
`define EXRS_CCR_I_BIT      7
`define EXRS_CCR_UI_BIT     6
`define EXRS_ADDR_W         16
`define EXRS_PC_W           24
`define EXRS_PHASE_W        2
`define EXRS_PHASE_LAST8    2'h3
`define EXRS_PHASE_LAST16   2'h1
`define EXRS_FLAGS_RST      8'h80

`endif

// [rtl/exrs_pkg.sv]
/*
  Types of the exception and reset sequencer.
  Assumes nothing of its surroundings.
*/
package exrs_pkg;

  typedef enum logic [2:0] {
    EXRS_ST_RESET,
    EXRS_ST_INIT,
    EXRS_ST_RUN,
    EXRS_ST_PUSH_PC,
    EXRS_ST_PUSH_CCR,
    EXRS_ST_VEC_READ,
    EXRS_ST_JUMP
  } exrs_state_e;

  // Request toward the memory bus
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [23:0] wdata;
    logic        wide;
  } exrs_bus_s;

endpackage

// [rtl/exrs_seq.sv]
/*
  Exception and reset sequencer for a small CPU core.
  Assumes the core reports instruction boundaries and traps, the interrupt
  controller supplies a vector number, and the bus acknowledges each access.
*/
`timescale 1ns/1ps
`default_nettype none
`include "exrs_map.svh"

module exrs_seq (
  input  wire logic                   mclk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   chip_init_pin_n_i,
  input  wire logic                   wdt_ovf_i,
  input  wire logic                   bus16_i,
  input  wire logic                   user_flag_select_i,
  input  wire logic                   instr_done_i,
  input  wire logic                   soft_trap_instruction_i,
  input  wire logic [1:0]             trap_num_i,
  input  wire logic                   irq_req_i,
  input  wire logic [5:0]             irq_vec_i,
  input  wire logic [23:0]            instr_pointer_i,
  input  wire logic [7:0]             cond_flags_reg_i,
  input  wire logic                   bus_ack_i,
  input  wire logic [15:0]            bus_rdata_i,
  output var exrs_pkg::exrs_bus_s     bus_o,
  output logic                        core_halt_o,
  output logic                        periph_init_o,
  output logic                        irq_ack_o,
  output logic [7:0]                  cond_flags_reg_o,
  output logic                        flags_load_o,
  output logic [23:0]                 instr_pointer_o,
  output logic                        jump_o
);

  exrs_pkg::exrs_state_e state_q, state_d;
  logic [5:0]  vec_q;
  logic        is_trap_q;
  logic        irq_block_q;
  logic        pin_q;
  logic [1:0]  phase_q;
  logic [31:0] vec_data_q;
  logic [7:0]  flags_q;
  logic        wdt_q;
  logic        wdt_pend_q;
  logic        trap_pend_q;
  logic [1:0]  trap_num_q;

  wire reset_hold = !chip_init_pin_n_i;
  wire reset_rise = chip_init_pin_n_i && !pin_q;
  wire in_run     = (state_q == exrs_pkg::EXRS_ST_RUN);
  wire boundary   = in_run && instr_done_i;
  wire take_irq   = boundary && irq_req_i && !irq_block_q;
  // A trap that loses to a same-cycle interrupt is held and served next
  wire trap_now   = soft_trap_instruction_i || trap_pend_q;
  wire [1:0] trap_sel = trap_pend_q ? trap_num_q : trap_num_i;
  wire take_trap  = in_run && trap_now && !take_irq;
  // Watchdog entry has no pin edge, so it is remembered until init
  wire start_rst  = reset_rise || (wdt_pend_q && chip_init_pin_n_i);
  wire [1:0] last_phase = bus16_i ? `EXRS_PHASE_LAST16 : `EXRS_PHASE_LAST8;
  wire vec_done   = bus_ack_i && (phase_q == last_phase);
  wire vec_step   = (state_q == exrs_pkg::EXRS_ST_VEC_READ) && bus_ack_i;
  // Address of the next read, so it moves on at the acknowledging edge
  wire [1:0] phase_nx = !vec_step ? phase_q
                                  : (vec_done ? 2'h0 : phase_q + 2'h1);
  wire [5:0] vec_sel = (vec_q > `EXRS_VEC_MAX) ? `EXRS_VEC_MAX : vec_q;
  wire [15:0] vec_base = {8'h00, vec_sel, 2'h0};
  wire [15:0] vec_addr = bus16_i ? vec_base + {13'h0, phase_nx, 1'h0}
                                 : vec_base + {14'h0, phase_nx};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      exrs_pkg::EXRS_ST_RESET:    if (start_rst) state_d = exrs_pkg::EXRS_ST_INIT;
      exrs_pkg::EXRS_ST_INIT:     state_d = exrs_pkg::EXRS_ST_VEC_READ;
      exrs_pkg::EXRS_ST_RUN:      if (take_irq || take_trap)
                                    state_d = exrs_pkg::EXRS_ST_PUSH_PC;
      exrs_pkg::EXRS_ST_PUSH_PC:  if (bus_ack_i) state_d = exrs_pkg::EXRS_ST_PUSH_CCR;
      exrs_pkg::EXRS_ST_PUSH_CCR: if (bus_ack_i) state_d = exrs_pkg::EXRS_ST_VEC_READ;
      exrs_pkg::EXRS_ST_VEC_READ: if (vec_done) state_d = exrs_pkg::EXRS_ST_JUMP;
      exrs_pkg::EXRS_ST_JUMP:     state_d = exrs_pkg::EXRS_ST_RUN;
      default:                    state_d = exrs_pkg::EXRS_ST_RESET;
    endcase
    if (reset_hold || wdt_q) state_d = exrs_pkg::EXRS_ST_RESET;
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= exrs_pkg::EXRS_ST_RESET;
      pin_q   <= 1'b0;
      wdt_q   <= 1'b0;
      wdt_pend_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pin_q   <= chip_init_pin_n_i;
      wdt_q   <= wdt_ovf_i && !wdt_q;
      if (wdt_q)
        wdt_pend_q <= 1'b1;
      else if (state_q == exrs_pkg::EXRS_ST_INIT)
        wdt_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vec_q       <= `EXRS_VEC_RESET;
      is_trap_q   <= 1'b0;
      irq_block_q <= 1'b1;
      phase_q     <= '0;
      vec_data_q  <= '0;
      flags_q     <= '0;
      trap_pend_q <= 1'b0;
      trap_num_q  <= 2'h0;
    end else begin
      if (state_q == exrs_pkg::EXRS_ST_RESET) begin
        vec_q       <= `EXRS_VEC_RESET;
        irq_block_q <= 1'b1;
        phase_q     <= '0;
        trap_pend_q <= 1'b0;
      end
      if (in_run && instr_done_i) irq_block_q <= 1'b0;
      if (take_irq) begin
        vec_q     <= irq_vec_i;
        is_trap_q <= 1'b0;
        flags_q   <= cond_flags_reg_i;
        if (soft_trap_instruction_i) begin
          trap_pend_q <= 1'b1;
          trap_num_q  <= trap_num_i;
        end
      end else if (take_trap) begin
        vec_q     <= `EXRS_TRAP_VEC_BASE + {4'h0, trap_sel};
        is_trap_q <= 1'b1;
        flags_q   <= cond_flags_reg_i;
        trap_pend_q <= 1'b0;
      end
      if (state_q == exrs_pkg::EXRS_ST_VEC_READ && bus_ack_i) begin
        phase_q <= vec_done ? 2'h0 : phase_q + 2'h1;
        vec_data_q <= bus16_i ? {vec_data_q[15:0], bus_rdata_i}
                              : {vec_data_q[23:0], bus_rdata_i[7:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  wire in_reset = (state_q == exrs_pkg::EXRS_ST_RESET);
  wire in_init  = (state_q == exrs_pkg::EXRS_ST_INIT);
  logic [7:0] new_flags;
  always_comb begin
    new_flags = in_init ? 8'h00 : flags_q;
    new_flags[`EXRS_CCR_I_BIT] = 1'b1;
    if (is_trap_q && !in_init && !user_flag_select_i)
      new_flags[`EXRS_CCR_UI_BIT] = 1'b1;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_o            <= '0;
      core_halt_o      <= 1'b1;
      periph_init_o    <= 1'b1;
      irq_ack_o        <= 1'b0;
      cond_flags_reg_o <= `EXRS_FLAGS_RST;
      flags_load_o     <= 1'b0;
      instr_pointer_o  <= '0;
      jump_o           <= 1'b0;
    end else begin
      core_halt_o   <= (state_d != exrs_pkg::EXRS_ST_RUN);
      periph_init_o <= in_reset || in_init;
      irq_ack_o     <= take_irq;
      flags_load_o  <= in_init || (state_q == exrs_pkg::EXRS_ST_PUSH_CCR && bus_ack_i);
      if (in_init || (state_q == exrs_pkg::EXRS_ST_PUSH_CCR && bus_ack_i))
        cond_flags_reg_o <= new_flags;
      jump_o <= (state_q == exrs_pkg::EXRS_ST_JUMP);
      if (state_q == exrs_pkg::EXRS_ST_JUMP)
        instr_pointer_o <= vec_data_q[23:0];
      bus_o.rd    <= (state_d == exrs_pkg::EXRS_ST_VEC_READ);
      bus_o.wr    <= (state_d == exrs_pkg::EXRS_ST_PUSH_PC) ||
                     (state_d == exrs_pkg::EXRS_ST_PUSH_CCR);
      bus_o.wide  <= bus16_i;
      bus_o.addr  <= (state_d == exrs_pkg::EXRS_ST_VEC_READ)
                     ? vec_addr : 16'h0000;
      bus_o.wdata <= (state_d == exrs_pkg::EXRS_ST_PUSH_CCR)
                     ? {16'h0000, flags_q} : instr_pointer_i;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_reset_holds: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !chip_init_pin_n_i |=> state_q == exrs_pkg::EXRS_ST_RESET)
    else $error("reset pin low but not in reset");
  a_rise_starts: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (in_reset && reset_rise && !wdt_q) |=> in_init)
    else $error("no init after pin rise");
  a_init_mask: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    in_init && !reset_hold && !wdt_q |=> cond_flags_reg_o[`EXRS_CCR_I_BIT])
    else $error("mask not set at init");
  a_no_stack: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    in_init |=> !bus_o.wr)
    else $error("reset stacked");
  a_irq_first: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    take_irq |-> !take_trap)
    else $error("trap beat interrupt");
  a_irq_bound: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    irq_ack_o |-> $past(instr_done_i) && $past(in_run))
    else $error("interrupt taken mid instruction");
  a_block_reset: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    in_reset |=> !irq_ack_o)
    else $error("interrupt after reset");
  a_trap_taken: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (take_trap && !reset_hold && !wdt_q) |=> state_q == exrs_pkg::EXRS_ST_PUSH_PC)
    else $error("trap ignored");
  a_wdt_reset: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wdt_q |=> in_reset)
    else $error("watchdog not resetting");

  c_reset_jump: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    in_init ##[1:20] jump_o);
  c_irq: cover property (@(posedge mclk_i) disable iff (!rst_n_i) take_irq);
  c_trap: cover property (@(posedge mclk_i) disable iff (!rst_n_i) take_trap);

endmodule // exrs_seq

`default_nettype wire

// [verification/exrs_mem_model.sv]
/*
  Vector memory answering the sequencer's bus requests.
  Assumes each request is held until acknowledged, and that byte a holds a^5a.
*/
`timescale 1ns/1ps
`default_nettype none
module exrs_mem_model (
  input  wire logic                mclk_i,
  input  wire logic                rst_n_i,
  input  wire exrs_pkg::exrs_bus_s bus_i,
  input  wire logic [3:0]          lat_i,
  output logic                     ack_o,
  output logic [15:0]              rdata_o
);
  logic [3:0] cnt_q;
  function automatic logic [7:0] bt(input logic [15:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction
  // Data toggles whenever nothing is being answered
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o   <= 1'b0;
      cnt_q   <= 4'h0;
      rdata_o <= 16'h0000;
    end else if (ack_o || !(bus_i.rd || bus_i.wr)) begin
      ack_o   <= 1'b0;
      cnt_q   <= 4'h0;
      rdata_o <= ~rdata_o;
    end else if (cnt_q < lat_i) begin
      cnt_q   <= cnt_q + 4'h1;
      rdata_o <= ~rdata_o;
    end else begin
      ack_o   <= 1'b1;
      rdata_o <= bus_i.wide ? {bt(bus_i.addr), bt(bus_i.addr + 16'h0001)}
                            : {8'h00, bt(bus_i.addr)};
    end
  end
endmodule // exrs_mem_model
`default_nettype wire

// [verification/exrs_seq_tb.sv]
/*
  Self-checking bench of the exception and reset sequencer.
  Assumes exrs_mem_model answers the bus; inputs change at falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module exrs_seq_tb;
  logic mclk_i = 1'b0, rst_n_i = 1'b0, pin_n = 1'b0, wdt = 1'b0;
  logic bus16 = 1'b0, ufs = 1'b1, done = 1'b0, trap = 1'b0, irq = 1'b0;
  logic [1:0] tnum = 2'h0;
  logic [5:0] ivec = 6'h00;
  logic [3:0] lat = 4'h0;
  logic ack, halt, pinit, iack, fload, jump;
  logic [15:0] rdata;
  logic [7:0] flo;
  logic [23:0] ipo;
  exrs_pkg::exrs_bus_s bus;
  int fail_count = 0, check_count = 0, rd_n, wr_n, ack_n, cyc = 0;

  exrs_seq exrs_seq_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .chip_init_pin_n_i(pin_n), .wdt_ovf_i(wdt), .bus16_i(bus16),
    .user_flag_select_i(ufs), .instr_done_i(done),
    .soft_trap_instruction_i(trap), .trap_num_i(tnum), .irq_req_i(irq),
    .irq_vec_i(ivec), .instr_pointer_i(24'h123456),
    .cond_flags_reg_i(8'h05), .bus_ack_i(ack), .bus_rdata_i(rdata),
    .bus_o(bus), .core_halt_o(halt), .periph_init_o(pinit),
    .irq_ack_o(iack), .cond_flags_reg_o(flo), .flags_load_o(fload),
    .instr_pointer_o(ipo), .jump_o(jump));
  exrs_mem_model exrs_mem_model_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .bus_i(bus), .lat_i(lat), .ack_o(ack), .rdata_o(rdata));

  initial begin
    forever #12.5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    if (ack && bus.rd) rd_n++;
    if (ack && bus.wr) wr_n++;
    if (iack) ack_n++;
    if (++cyc >= 20000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] bt(input int a);
    return 8'(a) ^ 8'h5a;
  endfunction
  function automatic logic [23:0] vec(input int n);
    return {bt(4*n+1), bt(4*n+2), bt(4*n+3)};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic arm();
    rd_n = 0; wr_n = 0; ack_n = 0;
  endtask
  task automatic wait_jump(input logic [23:0] pc, input int nrd, nwr);
    int n;
    n = 0;
    while (jump !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    check(ipo, pc);
    check(rd_n, nrd);
    check(wr_n, nwr);
  endtask

  // Pin held low, then released; bus width chosen per call
  task automatic t_reset(input logic w);
    pin_n = 1'b0; bus16 = w;
    tick(12);
    check(halt, 1);
    check(bus.rd | bus.wr, 0);
    check(pinit, 1);
    arm(); pin_n = 1'b1;
    wait_jump(vec(0), w ? 2 : 4, 0);
    check(flo[7], 1);
  endtask
  task automatic t_irq();
    irq = 1'b1; ivec = 6'h3c; arm(); tick(6);
    check(ack_n, 0);
    irq = 1'b0; done = 1'b1; tick(1); done = 1'b0;
    irq = 1'b1; tick(3); done = 1'b1; tick(1); done = 1'b0;
    wait_jump(vec(60), 2, 2);
    irq = 1'b0;
    check(ack_n, 1);
    check(flo, 8'h85);
  endtask
  task automatic t_trap();
    lat = 4'h2;
    for (int n = 0; n < 4; n++) begin
      ufs = n[0]; tnum = 2'(n); arm(); trap = 1'b1; tick(1); trap = 1'b0;
      wait_jump(vec(8 + n), 2, 2);
      check(flo, {1'b1, ~ufs, 6'h05});
    end
    lat = 4'h0;
  endtask
  task automatic t_both();
    irq = 1'b1; ivec = 6'h14; tnum = 2'h0; arm();
    done = 1'b1; trap = 1'b1; tick(1); done = 1'b0; trap = 1'b0;
    wait_jump(vec(20), 2, 2);
    irq = 1'b0; arm(); tick(1);
    wait_jump(vec(8), 2, 2);
  endtask
  task automatic t_wdt();
    arm(); wdt = 1'b1; tick(1); wdt = 1'b0;
    wait_jump(vec(0), 2, 0);
  endtask

  initial begin
    tick(12); // Power-up hold, shortened to keep the run brief
    rst_n_i = 1'b1;
    t_reset(1'b0);
    t_reset(1'b1);
    t_irq();
    t_trap();
    t_both();
    t_wdt();
    trap = 1'b1; tick(1); trap = 1'b0; tick(2);
    t_reset(1'b1);
    conclude();
  end
endmodule // exrs_seq_tb
`default_nettype wire
